// ===== dv/efa_loader_bench.sv
// self-checking bench for the function access loader
`timescale 1ns/1ns
`default_nettype none

module efa_loader_bench;
  import efa_pkg::*;

  logic           pclk;
  logic           presetn;
  logic           psel;
  logic           penable;
  logic           pwrite;
  logic [11:0]    paddr;
  logic [31:0]    pwdata;
  logic [31:0]    prdata;
  logic           pready;
  logic           pslverr;
  logic           mem_req;
  logic [7:0]     mem_addr;
  logic [15:0]    mem_rdata;
  logic           mem_ack;
  logic           fn_req;
  efa_access_type fn_access;
  logic           fn_ack;
  logic [1:0]     fn_wait;
  logic [7:0]     last_addr;
  logic [31:0]    last_rd;
  logic           last_err;
  efa_access_type seen [$];
  efa_access_type want [$];
  int             fail_count;
  int             comparisons;

  efa_loader #(.MEM_AW(8)) dut (
    .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_req(mem_req), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack), .fn_req(fn_req), .fn_access(fn_access), .fn_ack(fn_ack)
  );

  efa_mem_model #(.MEM_AW(8)) mem_i (
    .pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack)
  );

  // ==================================================================
  // clock and watchdog; a full run takes a few hundred cycles
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  initial
  begin
    #80000;
    fail_count++;
    end_of_test();
  end

  // ==================================================================
  // function side: ack delay follows the offset so both fast and slow occur
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fn_ack  <= 1'b0;
      fn_wait <= 2'd0;
    end
    else if (fn_ack)
      fn_ack <= 1'b0;
    else if (fn_req && fn_wait == fn_access.offset[1:0])
    begin
      fn_ack  <= 1'b1;
      fn_wait <= 2'd0;
    end
    else if (fn_req)
      fn_wait <= fn_wait + 2'd1;
  end

  // record completed accesses and the last word address taken
  always @(posedge pclk)
  begin
    if (fn_req && fn_ack)
      seen.push_back(fn_access);
    if (mem_req && mem_ack)
      last_addr <= mem_addr;
  end

  // ==================================================================
  // compare and report
  task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_access(input efa_access_type exp, input efa_access_type got);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value fn_access expected %h seen %h", exp, got);
    end
  endtask

  task automatic end_of_test();
    if (fail_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ==================================================================
  // apb master: hold everything until pready, then release for one cycle
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      check_word("pready", 32'h0000_0001, 32'h0000_0000);
    last_rd  = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    check_word(name, exp, last_rd);
  endtask

  // expected access worked out from a first word and a data byte
  function automatic efa_access_type acc(input logic [15:0] w1, input logic [7:0] d);
    efa_access_type a;
    a.sel_serial   = (w1[10:8] == 3'h0);
    a.sel_parallel = (w1[10:8] == 3'h1);
    a.bar          = w1[14:12];
    a.is_write     = w1[11];
    a.offset       = w1[7:0];
    a.data         = d;
    return a;
  endfunction

  // start a zone, wait for done, then compare status, count and accesses
  task automatic run_zone(input logic [7:0] base, input logic [31:0] ctrl,
                          input logic [31:0] stat, input logic [31:0] pairs);
    int n;
    seen.delete();
    xfer(1'b1, 12'h004, {24'h00_0000, base});
    xfer(1'b1, 12'h000, ctrl);
    n = 0;
    do
    begin
      xfer(1'b0, 12'h008, 32'h0000_0000);
      n++;
    end
    while (last_rd[1] !== 1'b1 && n < 100);
    check_word("status", stat, last_rd);
    rd_chk("pairs", 12'h00c, pairs);
    check_word("access count", want.size(), seen.size());
    foreach (want[i])
      if (i < seen.size())
        check_access(want[i], seen[i]);
    want.delete();
  endtask

  // ==================================================================
  // main sequence
  initial
  begin
    fail_count = 0;
    comparisons = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    // reset values and an unmapped place
    rd_chk("ctrl", 12'h000, 32'h0000_0000);
    rd_chk("start_addr", 12'h004, 32'h0000_0000);
    rd_chk("status", 12'h008, 32'h0000_0000);
    rd_chk("pairs", 12'h00c, 32'h0000_0000);
    rd_chk("unmapped", 12'h010, 32'h0000_0000);
    check_word("pslverr", 32'h0000_0001, {31'h0, last_err});
    // zone with writes, a parallel write, a reserved function and a read
    mem_i.mem[8'h10] = 16'h8804;
    mem_i.mem[8'h11] = 16'h8010;
    mem_i.mem[8'h12] = 16'h9802;
    mem_i.mem[8'h13] = 16'h8001;
    mem_i.mem[8'h14] = 16'h8905;
    mem_i.mem[8'h15] = 16'h8055;
    mem_i.mem[8'h16] = 16'h8a03;
    mem_i.mem[8'h17] = 16'h8000;
    mem_i.mem[8'h18] = 16'h8001;
    mem_i.mem[8'h19] = 16'h8000;
    mem_i.mem[8'h1a] = 16'h0000;
    mem_i.mem[8'h1b] = 16'h8807;
    mem_i.mem[8'h1c] = 16'h80aa;
    want = {acc(16'h8804, 8'h10), acc(16'h9802, 8'h01), acc(16'h8905, 8'h55),
            acc(16'h8001, 8'h00)};
    run_zone(8'h10, 32'h0000_0001, 32'h0000_000a, 32'h0000_0004);
    check_word("last word", 32'h0000_001a, {24'h0, last_addr});
    // malformed second words are still carried out, and flagged
    mem_i.mem[8'h40] = 16'hc8ff;
    mem_i.mem[8'h41] = 16'h0033;
    mem_i.mem[8'h42] = 16'h8801;
    mem_i.mem[8'h43] = 16'h8101;
    mem_i.mem[8'h44] = 16'h0000;
    want = {acc(16'hc8ff, 8'h33), acc(16'h8801, 8'h01)};
    run_zone(8'h40, 32'h0000_0001, 32'h0000_0006, 32'h0000_0002);
    // reserved function with halt set stops the zone there
    mem_i.mem[8'h60] = 16'h8b00;
    mem_i.mem[8'h61] = 16'h8000;
    mem_i.mem[8'h62] = 16'h8807;
    mem_i.mem[8'h63] = 16'h8011;
    run_zone(8'h60, 32'h0000_0003, 32'h0000_000a, 32'h0000_0000);
    check_word("last word", 32'h0000_0061, {24'h0, last_addr});
    rd_chk("ctrl", 12'h000, 32'h0000_0002);
    end_of_test();
  end
endmodule

`default_nettype wire

// ===== dv/efa_mem_model.sv
// configuration memory model answering word fetches from the loader
`timescale 1ns/1ns
`default_nettype none

module efa_mem_model #(
  parameter int MEM_AW = 8
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              mem_req,
  input  wire logic [MEM_AW-1:0] mem_addr,
  output var  logic [15:0]       mem_rdata,
  output var  logic              mem_ack
);
  logic [15:0] mem [2**MEM_AW];
  logic [1:0]  wait_reg;

  // ==================================================================
  // word answer
  // odd addresses answer two cycles late, even ones at once; outside the
  // ack cycle the data line toggles so a stale word is never mistaken
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mem_ack   <= 1'b0;
      mem_rdata <= 16'hffff;
      wait_reg  <= 2'd0;
    end
    else if (mem_ack)
    begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end
    else if (mem_req && wait_reg == {mem_addr[0], 1'b0})
    begin
      mem_ack   <= 1'b1;
      mem_rdata <= mem[mem_addr]; // words in memory order
      wait_reg  <= 2'd0;
    end
    else
    begin
      mem_rdata <= ~mem_rdata;
      wait_reg  <= mem_req ? wait_reg + 2'd1 : 2'd0;
    end
  end
endmodule

`default_nettype wire

// ===== hw/efa_apb_regs.sv
// apb slave with the loader control and status registers
`include "efa_loader_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module efa_apb_regs #(
  parameter int MEM_AW = 8
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   ce,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output var  logic [31:0]            prdata,
  output var  logic                   pready,
  output var  logic                   pslverr,
  output var  logic                   start_pulse,
  output var  logic                   halt_err,
  output var  logic [MEM_AW-1:0]      start_addr,
  input  wire efa_pkg::efa_status_type status
);
  import efa_pkg::*;

  logic [31:0]       prdata_next;
  logic              pready_next;
  logic              pslverr_next;
  logic              start_next;
  logic              halt_next;
  logic [MEM_AW-1:0] start_addr_next;

  // unmapped offsets answer with pslverr
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `EFA_OFF_CTRL) || (a == `EFA_OFF_START_ADDR) ||
             (a == `EFA_OFF_STATUS) || (a == `EFA_OFF_PAIRS);
  endfunction

  // read mux; reserved bits read zero and start reads back zero
  function automatic logic [31:0] rd_word(input logic [11:0] a);
    rd_word = 32'h0000_0000;
    if (a == `EFA_OFF_CTRL)
      rd_word[`EFA_CTRL_HALT_ERR] = halt_err;
    else if (a == `EFA_OFF_START_ADDR)
      rd_word[MEM_AW-1:0] = start_addr;
    else if (a == `EFA_OFF_STATUS)
    begin
      rd_word[`EFA_STAT_BUSY]     = status.busy;
      rd_word[`EFA_STAT_DONE]     = status.done;
      rd_word[`EFA_STAT_WORD_ERR] = status.word_err;
      rd_word[`EFA_STAT_FUNC_ERR] = status.func_err;
    end
    else if (a == `EFA_OFF_PAIRS)
      rd_word[15:0] = status.pairs;
  endfunction

  // ==================================================================
  // one wait state: pready raised in the second access cycle
  always_comb
  begin
    prdata_next     = prdata;
    pready_next     = 1'b0;
    pslverr_next    = 1'b0;
    start_next      = 1'b0;
    halt_next       = halt_err;
    start_addr_next = start_addr;
    if (psel && penable && !pready)
    begin
      pready_next  = 1'b1;
      pslverr_next = !mapped(paddr);
      if (!pwrite)
        prdata_next = rd_word(paddr);
    end
    if (psel && penable && pready && pwrite)
    begin
      if (paddr == `EFA_OFF_CTRL)
      begin
        start_next = pwdata[`EFA_CTRL_START];
        halt_next  = pwdata[`EFA_CTRL_HALT_ERR];
      end
      else if (paddr == `EFA_OFF_START_ADDR)
        start_addr_next = pwdata[MEM_AW-1:0];
    end
  end

  // register stage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata      <= 32'h0000_0000;
      pready      <= 1'b0;
      pslverr     <= 1'b0;
      start_pulse <= 1'b0;
      halt_err    <= `EFA_RST_HALT_ERR;
      start_addr  <= '0;
    end
    else if (ce)
    begin
      prdata      <= prdata_next;
      pready      <= pready_next;
      pslverr     <= pslverr_next;
      start_pulse <= start_next;
      halt_err    <= halt_next;
      start_addr  <= start_addr_next;
    end
  end

endmodule

`default_nettype wire

// ===== hw/efa_loader.sv
// function access zone loader: replays memory word pairs as register accesses
//
// Design decisions made here: the placing of the registers and the APB register port.
`include "efa_loader_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module efa_loader #(
  parameter int MEM_AW = 8
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   ce,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output var  logic [31:0]            prdata,
  output var  logic                   pready,
  output var  logic                   pslverr,
  output var  logic                   mem_req,
  output var  logic [MEM_AW-1:0]      mem_addr,
  input  wire logic [15:0]            mem_rdata,
  input  wire logic                   mem_ack,
  output var  logic                   fn_req,
  output var  efa_pkg::efa_access_type fn_access,
  input  wire logic                   fn_ack
);
  import efa_pkg::*;

  // ==================================================================
  // declarations
  efa_state_type     state_reg,      state_next;
  logic [MEM_AW-1:0] ptr_reg,        ptr_next;
  logic [15:0]       word1_reg,      word1_next;
  logic              fetch_go_reg,   fetch_go_next;
  logic              fn_req_next;
  efa_access_type    fn_access_next;
  efa_status_type    status_reg,     status_next;
  logic              start_pulse;
  logic              halt_err;
  logic [MEM_AW-1:0] start_addr;
  logic              word_valid;
  logic [15:0]       word;
  logic [2:0]        func_code;

  // reserved function codes are neither serial nor parallel
  function automatic logic func_known(input logic [2:0] f);
    func_known = (f == `EFA_FUNC_SERIAL) || (f == `EFA_FUNC_PARALLEL);
  endfunction

  assign func_code = word1_reg[`EFA_W1_FUNC_HI:`EFA_W1_FUNC_LO];

  // ==================================================================
  // register slave
  efa_apb_regs #(
    .MEM_AW (MEM_AW)
  ) u_regs (
    .pclk        (pclk),
    .presetn     (presetn),
    .ce          (ce),
    .psel        (psel),
    .penable     (penable),
    .pwrite      (pwrite),
    .paddr       (paddr),
    .pwdata      (pwdata),
    .prdata      (prdata),
    .pready      (pready),
    .pslverr     (pslverr),
    .start_pulse (start_pulse),
    .halt_err    (halt_err),
    .start_addr  (start_addr),
    .status      (status_reg)
  );

  // ==================================================================
  // memory word fetch
  efa_word_fetch #(
    .MEM_AW (MEM_AW)
  ) u_fetch (
    .pclk       (pclk),
    .presetn    (presetn),
    .ce         (ce),
    .fetch_go   (fetch_go_reg),
    .fetch_addr (ptr_reg),
    .mem_req    (mem_req),
    .mem_addr   (mem_addr),
    .mem_rdata  (mem_rdata),
    .mem_ack    (mem_ack),
    .word_valid (word_valid),
    .word       (word)
  );

  // ==================================================================
  // sequencer: fetch first word, fetch second word, access, repeat
  always_comb
  begin
    state_next     = state_reg;
    ptr_next       = ptr_reg;
    word1_next     = word1_reg;
    fetch_go_next  = 1'b0;
    fn_req_next    = fn_req;
    fn_access_next = fn_access;
    status_next    = status_reg;
    unique case (state_reg)
      ST_IDLE, ST_DONE:
      begin
        // a start while busy is ignored; only these states accept it
        if (start_pulse)
        begin
          ptr_next      = start_addr;
          fetch_go_next = 1'b1;
          status_next   = '{busy: 1'b1, done: 1'b0, word_err: 1'b0,
                            func_err: 1'b0, pairs: 16'h0000};
          state_next    = ST_FETCH1;
        end
      end
      ST_FETCH1:
      begin
        if (word_valid)
        begin
          ptr_next = ptr_reg + 1'b1;
          if (word == 16'h0000)
          begin
            status_next.busy = 1'b0;
            status_next.done = 1'b1;
            state_next       = ST_DONE;
          end
          else
          begin
            word1_next    = word;
            fetch_go_next = 1'b1;
            state_next    = ST_FETCH2;
          end
        end
      end
      ST_FETCH2:
      begin
        if (word_valid)
        begin
          ptr_next = ptr_reg + 1'b1;
          // malformed second word is flagged but still used
          if (!word[`EFA_W2_MARK] || (word[`EFA_W2_RSV_HI:`EFA_W2_RSV_LO] != 7'h00))
            status_next.word_err = 1'b1;
          fn_access_next.sel_serial   = (func_code == `EFA_FUNC_SERIAL);
          fn_access_next.sel_parallel = (func_code == `EFA_FUNC_PARALLEL);
          fn_access_next.bar      = word1_reg[`EFA_W1_BAR_HI:`EFA_W1_BAR_LO];
          fn_access_next.offset   = word1_reg[`EFA_W1_OFF_HI:`EFA_W1_OFF_LO];
          fn_access_next.is_write = word1_reg[`EFA_W1_DIR];
          // read pairs put no data on the access port
          fn_access_next.data = word1_reg[`EFA_W1_DIR] ?
                                word[`EFA_W2_DATA_HI:`EFA_W2_DATA_LO] : 8'h00;
          if (func_known(func_code))
          begin
            fn_req_next = 1'b1;
            state_next  = ST_ACCESS;
          end
          else
          begin
            // reserved function: skipped, or the zone stops if asked
            status_next.func_err = 1'b1;
            if (halt_err)
            begin
              status_next.busy = 1'b0;
              status_next.done = 1'b1;
              state_next       = ST_DONE;
            end
            else
            begin
              fetch_go_next = 1'b1;
              state_next    = ST_FETCH1;
            end
          end
        end
      end
      ST_ACCESS:
      begin
        // read data is not taken at all, so nothing is stored
        if (fn_ack)
        begin
          fn_req_next       = 1'b0;
          status_next.pairs = status_reg.pairs + 16'h0001;
          fetch_go_next     = 1'b1;
          state_next        = ST_FETCH1;
        end
      end
    endcase
  end

  // sequencer registers, frozen while ce is low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg    <= ST_IDLE;
      ptr_reg      <= '0;
      word1_reg    <= `EFA_RST_WORD;
      fetch_go_reg <= 1'b0;
      fn_req       <= 1'b0;
      fn_access    <= '0;
      status_reg   <= '0;
    end
    else if (ce)
    begin
      state_reg    <= state_next;
      ptr_reg      <= ptr_next;
      word1_reg    <= word1_next;
      fetch_go_reg <= fetch_go_next;
      fn_req       <= fn_req_next;
      fn_access    <= fn_access_next;
      status_reg   <= status_next;
    end
  end

  // ==================================================================
  // assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !ce);

  sequence second_word_in;
    state_reg == ST_FETCH2 && word_valid;
  endsequence

  sequence known_pair;
    second_word_in ##0 func_known(func_code);
  endsequence

  end_word_a: assert property (state_reg == ST_FETCH1 && word_valid && word == 16'h0000
    |=> state_reg == ST_DONE && !fn_req && !fetch_go_reg && status_reg.done)
    else $error("zero word did not end the zone");

  offset_kept_a: assert property (known_pair
    |=> fn_req && fn_access.offset == $past(word1_reg[7:0])
        && fn_access.bar == $past(word1_reg[14:12]))
    else $error("access offset differs from first word");

  write_data_a: assert property (known_pair ##0 word1_reg[11]
    |=> fn_access.is_write && fn_access.data == $past(word[7:0]))
    else $error("write data differs from second word");

  read_clean_a: assert property (fn_req && !fn_access.is_write |-> fn_access.data == 8'h00)
    else $error("read access carries data");

  read_drop_a: assert property (fn_req && fn_ack && !fn_access.is_write
    |=> !fn_req && state_reg == ST_FETCH1 && $stable(fn_access))
    else $error("read completion mishandled");

  func_sel_a: assert property (fn_req |-> fn_access.sel_serial != fn_access.sel_parallel)
    else $error("access must select exactly one function");

  reserved_skip_a: assert property (second_word_in ##0 !func_known(func_code)
    |=> !fn_req && status_reg.func_err)
    else $error("reserved function was accessed");

  dir_bit_a: assert property (known_pair |=> fn_access.is_write == $past(word1_reg[11]))
    else $error("direction does not follow first word");

  access_first_a: assert property (fn_req |-> !mem_req && !fetch_go_reg)
    else $error("fetch started during a register access");

  next_pair_a: assert property (fn_req && fn_ack |=> fetch_go_reg ##1 mem_req
    && mem_addr == $past(ptr_reg))
    else $error("next pair not fetched after access");

  // stop and ordering checks; a halt must leave no fetch behind, a skip must fetch the next pair
  sequence reserved_pair;
    second_word_in ##0 !func_known(func_code);
  endsequence

  halt_stop_a: assert property (reserved_pair ##0 halt_err
    |=> state_reg == ST_DONE && !fetch_go_reg && status_reg.done)
    else $error("halt on reserved function did not stop the zone");

  skip_on_a: assert property (reserved_pair ##0 !halt_err
    |=> state_reg == ST_FETCH1 && fetch_go_reg && !status_reg.done)
    else $error("reserved pair was not skipped");

  word_order_a: assert property ((state_reg == ST_FETCH1 || state_reg == ST_FETCH2)
    && word_valid |=> ptr_reg == $past(ptr_reg) + 1'b1)
    else $error("word pointer did not step by one");

  addr_follow_a: assert property ($rose(mem_req)
    |-> mem_addr == ptr_reg)
    else $error("word fetched out of memory order");

  pairs_count_a: assert property (fn_req && fn_ack
    |=> status_reg.pairs == $past(status_reg.pairs) + 16'h0001)
    else $error("completed access not counted");

  idle_quiet_a: assert property (state_reg == ST_IDLE || state_reg == ST_DONE
    |-> !fn_req && !mem_req)
    else $error("activity after the zone ended");

endmodule

`default_nettype wire

// ===== hw/efa_loader_cfg.svh
// offsets, field positions, reset values and codes for the function access loader
`ifndef EFA_LOADER_CFG_SVH
`define EFA_LOADER_CFG_SVH

// ==================================================================
// register map (byte addresses, one 32-bit word each)
`define EFA_OFF_CTRL        12'h000
`define EFA_OFF_START_ADDR  12'h004
`define EFA_OFF_STATUS      12'h008
`define EFA_OFF_PAIRS       12'h00C

// ==================================================================
// control and status bit positions
`define EFA_CTRL_START      0
`define EFA_CTRL_HALT_ERR   1
`define EFA_STAT_BUSY       0
`define EFA_STAT_DONE       1
`define EFA_STAT_WORD_ERR   2
`define EFA_STAT_FUNC_ERR   3

// ==================================================================
// reset values
`define EFA_RST_HALT_ERR    1'b0
`define EFA_RST_WORD        16'h0000

// ==================================================================
// first word of an access pair
`define EFA_W1_BAR_HI       14
`define EFA_W1_BAR_LO       12
`define EFA_W1_DIR          11
`define EFA_W1_FUNC_HI      10
`define EFA_W1_FUNC_LO      8
`define EFA_W1_OFF_HI       7
`define EFA_W1_OFF_LO       0

// ==================================================================
// second word of an access pair
`define EFA_W2_MARK         15
`define EFA_W2_RSV_HI       14
`define EFA_W2_RSV_LO       8
`define EFA_W2_DATA_HI      7
`define EFA_W2_DATA_LO      0

// ==================================================================
// function codes
`define EFA_FUNC_SERIAL     3'h0
`define EFA_FUNC_PARALLEL   3'h1

`endif

// ===== hw/efa_pkg.sv
// types shared by the function access loader
`default_nettype none

package efa_pkg;

  // ==================================================================
  // sequencer states
  typedef enum logic [4:0]
  {
    ST_IDLE   = 5'b00001,
    ST_FETCH1 = 5'b00010,
    ST_FETCH2 = 5'b00100,
    ST_ACCESS = 5'b01000,
    ST_DONE   = 5'b10000
  } efa_state_type;

  // ==================================================================
  // one register access towards the internal functions
  typedef struct packed
  {
    logic       sel_serial;
    logic       sel_parallel;
    logic [2:0] bar;
    logic       is_write;
    logic [7:0] offset;
    logic [7:0] data;
  } efa_access_type;

  // ==================================================================
  // loader state as seen by software
  typedef struct packed
  {
    logic        busy;
    logic        done;
    logic        word_err;
    logic        func_err;
    logic [15:0] pairs;
  } efa_status_type;

endpackage

`default_nettype wire

// ===== hw/efa_word_fetch.sv
// word fetch handshake towards the configuration memory reader
`include "efa_loader_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module efa_word_fetch #(
  parameter int MEM_AW = 8
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              ce,
  input  wire logic              fetch_go,
  input  wire logic [MEM_AW-1:0] fetch_addr,
  output var  logic              mem_req,
  output var  logic [MEM_AW-1:0] mem_addr,
  input  wire logic [15:0]       mem_rdata,
  input  wire logic              mem_ack,
  output var  logic              word_valid,
  output var  logic [15:0]       word
);
  import efa_pkg::*;

  logic              req_next;
  logic [MEM_AW-1:0] addr_next;
  logic              valid_next;
  logic [15:0]       word_next;

  // ==================================================================
  // request held until the reader acknowledges with the word
  always_comb
  begin
    req_next   = mem_req;
    addr_next  = mem_addr;
    valid_next = 1'b0;
    word_next  = word;
    if (fetch_go)
    begin
      req_next  = 1'b1;
      addr_next = fetch_addr;
    end
    else if (mem_req && mem_ack)
    begin
      req_next   = 1'b0;
      valid_next = 1'b1;
      word_next  = mem_rdata;
    end
  end

  // state registers, frozen while ce is low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mem_req    <= 1'b0;
      mem_addr   <= '0;
      word_valid <= 1'b0;
      word       <= `EFA_RST_WORD;
    end
    else if (ce)
    begin
      mem_req    <= req_next;
      mem_addr   <= addr_next;
      word_valid <= valid_next;
      word       <= word_next;
    end
  end

endmodule

`default_nettype wire
